// *** hdl/pacc_pkg.sv ***
/*
  Constants, register map and types for the channel value and pulse
  accumulator block. Assumes a 32-bit classic Wishbone bus with byte
  addresses; register index times four is the byte address.
*/
package pacc_pkg;

  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned REG_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned CH_IDX_W = 3;
  localparam int unsigned DIV_W = 6;

  // Register indices, byte address = index * 4
  localparam logic [5:0] IDX_DIR = 6'h00;
  localparam logic [5:0] IDX_TCNT = 6'h04;
  localparam logic [5:0] IDX_TSC1 = 6'h06;
  localparam logic [5:0] IDX_CH_BASE = 6'h10;
  localparam logic [5:0] IDX_ACTL = 6'h20;
  localparam logic [5:0] IDX_AFLG = 6'h21;
  localparam logic [5:0] IDX_ACNT = 6'h22;

  // Timer system control 1 fields
  localparam int unsigned BIT_TMR_EN = 7;
  localparam int unsigned BIT_FFC = 4;

  // Accumulator control fields
  localparam int unsigned BIT_ACC_EN = 6;
  localparam int unsigned BIT_MODE = 5;
  localparam int unsigned BIT_EDGE = 4;
  localparam int unsigned BIT_CLK_HI = 3;
  localparam int unsigned BIT_CLK_LO = 2;
  localparam int unsigned BIT_OVF_IE = 1;
  localparam int unsigned BIT_IN_IE = 0;

  // Accumulator flag fields
  localparam int unsigned BIT_OVF = 1;
  localparam int unsigned BIT_INF = 0;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CH_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] LOW_BYTE_MAX = 8'hFF;
  localparam logic [5:0] DIV64_LAST = 6'h3F;
  localparam logic [5:0] DIV_ONE = 6'h01;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    CLKSRC_PRESC = 2'h0,
    CLKSRC_ACC = 2'h1,
    CLKSRC_ACC256 = 2'h2,
    CLKSRC_ACC64K = 2'h3
  } clk_src_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WORK,
    BUS_ACK
  } bus_state_t;

  function automatic logic is_ch_index(input logic [5:0] idx);
    is_ch_index = (idx[5:3] == IDX_CH_BASE[5:3]);
  endfunction : is_ch_index

endpackage : pacc_pkg

// *** hdl/cc_store_if.sv ***
/*
  Carrier between the register logic and the channel value store.
  Assumes both ends run on the same bus clock.
*/
`timescale 1ns/1ns
interface cc_store_if;
  logic [7:0] cap_we;
  logic [7:0] bus_we;
  logic [15:0] cap_val;
  logic [15:0] wr_val;
  logic [1:0] wr_lanes;
  logic [2:0] rd_idx;
  logic [15:0] rd_val;
  logic [15:0] cmp_val;
  logic [7:0] match;

  modport ctrl (
    output cap_we, bus_we, cap_val, wr_val, wr_lanes, rd_idx, cmp_val,
    input rd_val, match
  );
  modport store (
    input cap_we, bus_we, cap_val, wr_val, wr_lanes, rd_idx, cmp_val,
    output rd_val, match
  );
endinterface : cc_store_if

// *** hdl/channel_value_store.sv ***
/*
  Eight 16-bit channel capture/compare words with registered read and
  registered per-channel equality against the timer counter.
  Assumes the caller never writes one word by capture and bus at once.
*/
`timescale 1ns/1ns
module channel_value_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register side
  cc_store_if.store port
);

  logic [pacc_pkg::NUM_CH-1:0][15:0] word_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_r <= '0;
    end else begin
      for (int i = 0; i < pacc_pkg::NUM_CH; i++) begin
        if (port.cap_we[i]) begin
          word_r[i] <= port.cap_val;
        end else if (port.bus_we[i]) begin
          if (port.wr_lanes[0]) begin
            word_r[i][7:0] <= port.wr_val[7:0];
          end
          if (port.wr_lanes[1]) begin
            word_r[i][15:8] <= port.wr_val[15:8];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port.rd_val <= pacc_pkg::CH_RST;
    end else begin
      port.rd_val <= word_r[port.rd_idx];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port.match <= '0;
    end else begin
      for (int i = 0; i < pacc_pkg::NUM_CH; i++) begin
        port.match[i] <= (word_r[i] == port.cmp_val);
      end
    end
  end

endmodule : channel_value_store

// *** hdl/pulse_accum_top.sv ***
/*
  Timer channel value registers, 16-bit timer counter with clock select,
  and the 16-bit pulse accumulator on the channel 7 pin, behind a 32-bit
  classic Wishbone slave. Assumes all pins are asynchronous to SYS_CLK
  and that pulses on them last longer than two bus clocks.
*/
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
module pulse_accum_top (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_WDATA,
  output logic [31:0] WB_RDATA,
  output logic WB_ACK,
  // Channel pins, bit 7 also feeds the accumulator
  input wire logic [7:0] CH_PIN,
  // Events and interrupt requests
  output logic [7:0] OC_MATCH,
  output logic ACCUM_OVF_IRQ,
  output logic ACCUM_IN_IRQ
);

  localparam int unsigned CH7 = 7;

  cc_store_if store_bus ();

  channel_value_store channel_value_store_inst (
    .clk(SYS_CLK),
    .rst(RST),
    .port(store_bus.store)
  );

  // Registers
  pacc_pkg::bus_state_t state_r;
  logic [7:0] dir_r;
  logic timer_en_r;
  logic ffc_r;
  logic [7:0] ctrl_r;
  logic ovf_r;
  logic inf_r;
  logic [15:0] acnt_r;
  logic [15:0] tcnt_r;
  logic [5:0] div_r;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] sync3_r;
  logic [7:0] lvl_r;
  logic [7:0] lvl_prev_r;
  logic [7:0] match_prev_r;

  // Bus decode
  logic [5:0] idx;
  logic do_op;
  logic wr;
  logic acc_cnt_hit;
  logic [31:0] rdata_nxt;

  assign idx = WB_ADR[7:2];
  assign do_op = (state_r == pacc_pkg::BUS_WORK);
  assign wr = do_op && WB_WE;
  assign acc_cnt_hit = do_op && (idx == pacc_pkg::IDX_ACNT);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_r <= pacc_pkg::BUS_IDLE;
    end else begin
      unique case (state_r)
        pacc_pkg::BUS_IDLE: begin
          if (WB_CYC && WB_STB) begin
            state_r <= pacc_pkg::BUS_WORK;
          end
        end
        pacc_pkg::BUS_WORK: begin
          state_r <= pacc_pkg::BUS_ACK;
        end
        pacc_pkg::BUS_ACK: begin
          state_r <= pacc_pkg::BUS_IDLE;
        end
        // Unused fourth code falls back to idle
        default: begin
          state_r <= pacc_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      WB_ACK <= 1'b0;
      WB_RDATA <= pacc_pkg::RD_ZERO;
    end else begin
      WB_ACK <= do_op;
      if (do_op && !WB_WE) begin
        WB_RDATA <= rdata_nxt;
      end
    end
  end

  // Pin synchronisers: level accepted once stages two and three agree
  logic [7:0] agree;
  assign agree = ~(sync2_r ^ sync3_r);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      lvl_r <= '0;
      lvl_prev_r <= '0;
    end else begin
      sync1_r <= CH_PIN;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lvl_r <= (agree & sync2_r) | (~agree & lvl_r);
      lvl_prev_r <= lvl_r;
    end
  end

  logic [7:0] rise;
  logic [7:0] fall;
  assign rise = lvl_r & ~lvl_prev_r;
  assign fall = ~lvl_r & lvl_prev_r;

  // Control registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dir_r <= pacc_pkg::DIR_RST;
      timer_en_r <= 1'b0;
      ffc_r <= 1'b0;
      ctrl_r <= pacc_pkg::CTRL_RST;
    end else if (wr && WB_SEL[0]) begin
      if (idx == pacc_pkg::IDX_DIR) begin
        dir_r <= WB_WDATA[7:0];
      end
      if (idx == pacc_pkg::IDX_TSC1) begin
        timer_en_r <= WB_WDATA[pacc_pkg::BIT_TMR_EN];
        ffc_r <= WB_WDATA[pacc_pkg::BIT_FFC];
      end
      if (idx == pacc_pkg::IDX_ACTL) begin
        ctrl_r <= WB_WDATA[7:0];
      end
    end
  end

  logic acc_en;
  logic acc_mode;
  logic acc_edge;
  assign acc_en = ctrl_r[pacc_pkg::BIT_ACC_EN];
  assign acc_mode = ctrl_r[pacc_pkg::BIT_MODE];
  assign acc_edge = ctrl_r[pacc_pkg::BIT_EDGE];

  // Prescaler divide-by-64 runs only while the timer is enabled
  logic tick64;
  assign tick64 = timer_en_r && (div_r == pacc_pkg::DIV64_LAST);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      div_r <= '0;
    end else if (timer_en_r) begin
      div_r <= div_r + pacc_pkg::DIV_ONE;
    end
  end

  // Accumulator input on channel 7
  logic pa_lvl;
  logic pa_edge;
  logic gate_on;
  logic evt_inc;
  logic gate_inc;
  logic inc;
  logic in_set;
  assign pa_lvl = lvl_r[CH7];
  assign pa_edge = acc_edge ? rise[CH7] : fall[CH7];
  assign gate_on = acc_edge ? !pa_lvl : pa_lvl;
  // Event counting does not depend on the timer enable
  assign evt_inc = acc_en && !acc_mode && pa_edge;
  assign gate_inc = acc_en && acc_mode && gate_on && tick64;
  assign inc = evt_inc || gate_inc;
  // Selected edge sets the flag as gate end or counted edge alike: falling for a high gate, rising for a low one
  assign in_set = acc_en && pa_edge;

  // Accumulator count, bus write wins over a same-cycle increment
  logic acnt_wr;
  logic ovf_set;
  assign acnt_wr = wr && (idx == pacc_pkg::IDX_ACNT) && (WB_SEL[1:0] != 2'h0);
  assign ovf_set = inc && !acnt_wr && (acnt_r == pacc_pkg::CNT_MAX);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      acnt_r <= pacc_pkg::CNT_RST;
    end else if (acnt_wr) begin
      if (WB_SEL[0]) begin
        acnt_r[7:0] <= WB_WDATA[7:0];
      end
      if (WB_SEL[1]) begin
        acnt_r[15:8] <= WB_WDATA[15:8];
      end
    end else if (inc) begin
      acnt_r <= acnt_r + pacc_pkg::CNT_ONE;
    end
  end

  // Flags: set wins over any clear in the same cycle
  logic w1c_hit;
  logic fast_clr;
  logic ovf_clr;
  logic inf_clr;
  assign w1c_hit = wr && WB_SEL[0] && (idx == pacc_pkg::IDX_AFLG) && timer_en_r;
  assign fast_clr = acc_cnt_hit && ffc_r;
  assign ovf_clr = fast_clr || (w1c_hit && WB_WDATA[pacc_pkg::BIT_OVF]);
  assign inf_clr = fast_clr || (w1c_hit && WB_WDATA[pacc_pkg::BIT_INF]);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ovf_r <= 1'b0;
      inf_r <= 1'b0;
    end else begin
      ovf_r <= ovf_set || (ovf_r && !ovf_clr);
      inf_r <= in_set || (inf_r && !inf_clr);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ACCUM_OVF_IRQ <= 1'b0;
      ACCUM_IN_IRQ <= 1'b0;
    end else begin
      ACCUM_OVF_IRQ <= ovf_r && ctrl_r[pacc_pkg::BIT_OVF_IE];
      ACCUM_IN_IRQ <= inf_r && ctrl_r[pacc_pkg::BIT_IN_IE];
    end
  end

  // Timer counter clock: select is combinational, so a write acts at once
  pacc_pkg::clk_src_t clk_src;
  logic tcnt_tick;
  always_comb begin
    clk_src = pacc_pkg::CLKSRC_PRESC;
    if (acc_en) begin
      clk_src = pacc_pkg::clk_src_t'(ctrl_r[pacc_pkg::BIT_CLK_HI:pacc_pkg::BIT_CLK_LO]);
    end
  end

  always_comb begin
    tcnt_tick = 1'b0;
    unique case (clk_src)
      pacc_pkg::CLKSRC_PRESC: tcnt_tick = 1'b1;
      pacc_pkg::CLKSRC_ACC: tcnt_tick = inc;
      pacc_pkg::CLKSRC_ACC256: tcnt_tick = inc && (acnt_r[7:0] == pacc_pkg::LOW_BYTE_MAX);
      pacc_pkg::CLKSRC_ACC64K: tcnt_tick = inc && (acnt_r == pacc_pkg::CNT_MAX);
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tcnt_r <= pacc_pkg::CNT_RST;
    end else if (timer_en_r && tcnt_tick) begin
      tcnt_r <= tcnt_r + pacc_pkg::CNT_ONE;
    end
  end

  // Channel store control
  logic [7:0] ch_sel;
  always_comb begin
    ch_sel = '0;
    if (wr && pacc_pkg::is_ch_index(idx)) begin
      ch_sel[idx[2:0]] = 1'b1;
    end
  end

  assign store_bus.cap_we = rise & ~dir_r;
  assign store_bus.bus_we = ch_sel & dir_r;
  assign store_bus.cap_val = tcnt_r;
  assign store_bus.wr_val = WB_WDATA[15:0];
  assign store_bus.wr_lanes = WB_SEL[1:0];
  assign store_bus.rd_idx = idx[2:0];
  assign store_bus.cmp_val = tcnt_r;

  // Compare event: pulse on each new match of an output channel
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      match_prev_r <= '0;
      OC_MATCH <= '0;
    end else begin
      match_prev_r <= store_bus.match;
      OC_MATCH <= store_bus.match & ~match_prev_r & dir_r;
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rdata_nxt = pacc_pkg::RD_ZERO;
    if (pacc_pkg::is_ch_index(idx)) begin
      rdata_nxt[15:0] = store_bus.rd_val;
    end else begin
      unique case (idx)
        pacc_pkg::IDX_DIR: rdata_nxt[7:0] = dir_r;
        pacc_pkg::IDX_TCNT: rdata_nxt[15:0] = tcnt_r;
        pacc_pkg::IDX_TSC1: begin
          rdata_nxt[pacc_pkg::BIT_TMR_EN] = timer_en_r;
          rdata_nxt[pacc_pkg::BIT_FFC] = ffc_r;
        end
        pacc_pkg::IDX_ACTL: rdata_nxt[6:0] = ctrl_r[6:0];
        pacc_pkg::IDX_AFLG: begin
          rdata_nxt[pacc_pkg::BIT_OVF] = ovf_r;
          rdata_nxt[pacc_pkg::BIT_INF] = inf_r;
        end
        pacc_pkg::IDX_ACNT: rdata_nxt[15:0] = acnt_r;
        default: rdata_nxt = pacc_pkg::RD_ZERO;
      endcase
    end
  end

endmodule : pulse_accum_top

// *** tb/pulse_source.sv ***
/*
  Far-side pulse source on the channel 7 pin.
  Assumes the bench issues start only while busy is low.
*/
`timescale 1ns/1ns
module pulse_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command
  input wire logic idle_lvl,
  input wire logic start,
  input wire logic [7:0] n,
  input wire logic [7:0] width,
  // Pin side
  output logic pin,
  output logic busy
);
  logic [8:0] half_r;
  logic [7:0] tick_r;
  assign busy = (half_r != 9'h000);
  // Each half lasts width cycles; bench keeps it at 4 or more
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_r <= 9'h000;
      tick_r <= 8'h00;
      pin <= 1'b0;
    end else if (!busy) begin
      tick_r <= 8'h00;
      half_r <= start ? {n, 1'b0} : 9'h000;
      pin <= start ? ~idle_lvl : idle_lvl;
    end else if (tick_r == width - 8'h01) begin
      tick_r <= 8'h00;
      half_r <= half_r - 9'h001;
      pin <= (half_r == 9'h001) ? idle_lvl : ~pin;
    end else begin
      tick_r <= tick_r + 8'h01;
    end
  end
endmodule : pulse_source

// *** tb/pulse_accum_props.sv ***
/*
  Port-level checker for the pulse accumulator block.
  Assumes the bus answers as the top module's hand-over describes.
*/
`timescale 1ns/1ns
module pulse_accum_props (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Bus
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_WDATA,
  input wire logic WB_ACK,
  // Requests
  input wire logic [7:0] OC_MATCH,
  input wire logic ACCUM_OVF_IRQ,
  input wire logic ACCUM_IN_IRQ
);
  logic [5:0] idx;
  logic acc_hit;
  logic wr_hit;
  logic [7:0] dir_r;
  logic [7:0] ctl_r;
  logic [7:0] tsc_r;
  assign idx = WB_ADR[7:2];
  assign acc_hit = WB_CYC && WB_STB && WB_ACK;
  assign wr_hit = acc_hit && WB_WE && WB_SEL[0];
  // Shadows lag the design by one edge, so the ctl_r and dir_r checks skip open bus cycles
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dir_r <= 8'h00;
      ctl_r <= 8'h00;
      tsc_r <= 8'h00;
    end else if (wr_hit) begin
      if (idx == pacc_pkg::IDX_DIR) dir_r <= WB_WDATA[7:0];
      if (idx == pacc_pkg::IDX_ACTL) ctl_r <= WB_WDATA[7:0];
      if (idx == pacc_pkg::IDX_TSC1) tsc_r <= WB_WDATA[7:0];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_req_start; WB_CYC && WB_STB && !$past(WB_STB); endsequence
  sequence s_ack_walk; !WB_ACK ##1 !WB_ACK ##1 WB_ACK ##1 !WB_ACK; endsequence
  property p_ack; s_req_start |-> s_ack_walk; endproperty
  property p_rst; $fell(RST) |-> !WB_ACK && OC_MATCH == 8'h00 && !ACCUM_IN_IRQ; endproperty
  property p_ovf_ie;
    !ctl_r[pacc_pkg::BIT_OVF_IE] && !WB_CYC |-> !ACCUM_OVF_IRQ;
  endproperty
  property p_in_ie; !ctl_r[pacc_pkg::BIT_IN_IE] && !WB_CYC |-> !ACCUM_IN_IRQ; endproperty
  property p_fast;
    acc_hit && idx == pacc_pkg::IDX_ACNT && tsc_r[pacc_pkg::BIT_FFC]
      |=> !ACCUM_OVF_IRQ && !ACCUM_IN_IRQ;
  endproperty
  property p_w1c;
    wr_hit && idx == pacc_pkg::IDX_AFLG && WB_WDATA[pacc_pkg::BIT_INF]
      |=> (tsc_r[pacc_pkg::BIT_TMR_EN] ? !ACCUM_IN_IRQ : $stable(ACCUM_IN_IRQ));
  endproperty
  property p_dis;
    !ctl_r[pacc_pkg::BIT_ACC_EN] && !WB_CYC && !ACCUM_IN_IRQ |=> !ACCUM_IN_IRQ;
  endproperty
  property p_oc_dir;
    !WB_CYC && !$past(WB_CYC) && !$past(WB_CYC, 2) |-> (OC_MATCH & ~dir_r) == 8'h00;
  endproperty
  property p_oc_pulse; OC_MATCH != 8'h00 |=> (OC_MATCH & $past(OC_MATCH)) == 8'h00; endproperty
  a_ack: assert property (p_ack) else $error("bus answer out of step");
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  a_ovf_ie: assert property (p_ovf_ie) else $error("overflow request while masked");
  a_in_ie: assert property (p_in_ie) else $error("input request while masked");
  a_fast: assert property (p_fast) else $error("fast clear left a request");
  a_w1c: assert property (p_w1c) else $error("flag clear wrong for timer state");
  a_dis: assert property (p_dis) else $error("input request while disabled");
  a_oc_dir: assert property (p_oc_dir) else $error("match on capture channel");
  a_oc_pulse: assert property (p_oc_pulse) else $error("match longer than a cycle");
endmodule : pulse_accum_props

bind pulse_accum_top pulse_accum_props pulse_accum_props_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
  .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_WDATA(WB_WDATA), .WB_ACK(WB_ACK),
  .OC_MATCH(OC_MATCH), .ACCUM_OVF_IRQ(ACCUM_OVF_IRQ), .ACCUM_IN_IRQ(ACCUM_IN_IRQ)
);

// *** tb/tb_pulse_accumulator_channel_regs.sv ***
/*
  Self-checking bench for the pulse accumulator block.
  Assumes the pulse source model and the bound port checker.
*/
`timescale 1ns/1ns
module tb_pulse_accumulator_channel_regs;
  localparam logic [7:0] A_DIR = {pacc_pkg::IDX_DIR, 2'b00};
  localparam logic [7:0] A_TCNT = {pacc_pkg::IDX_TCNT, 2'b00};
  localparam logic [7:0] A_TSC1 = {pacc_pkg::IDX_TSC1, 2'b00};
  localparam logic [7:0] A_CH = {pacc_pkg::IDX_CH_BASE, 2'b00};
  localparam logic [7:0] A_ACTL = {pacc_pkg::IDX_ACTL, 2'b00};
  localparam logic [7:0] A_AFLG = {pacc_pkg::IDX_AFLG, 2'b00};
  localparam logic [7:0] A_ACNT = {pacc_pkg::IDX_ACNT, 2'b00};
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0;
  logic [7:0] WB_ADR = 8'h00;
  logic [3:0] WB_SEL = 4'h0;
  logic [31:0] WB_WDATA = 32'h0000_0000;
  logic [31:0] WB_RDATA;
  logic WB_ACK, ACCUM_OVF_IRQ, ACCUM_IN_IRQ;
  logic [7:0] OC_MATCH;
  logic [6:0] ch_lo = 7'h00;
  logic [3:0] bus_sel = 4'h3;
  logic src_pin, src_busy;
  logic src_idle = 1'b0, src_start = 1'b0;
  logic [7:0] src_n = 8'h00, src_w = 8'h04;
  int bad_count = 0;
  int n_checks = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  pulse_accum_top pulse_accum_top_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
    .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_WDATA(WB_WDATA), .WB_RDATA(WB_RDATA),
    .WB_ACK(WB_ACK), .CH_PIN({src_pin, ch_lo}), .OC_MATCH(OC_MATCH),
    .ACCUM_OVF_IRQ(ACCUM_OVF_IRQ), .ACCUM_IN_IRQ(ACCUM_IN_IRQ)
  );
  pulse_source pulse_source_inst (
    .clk(SYS_CLK), .rst(RST), .idle_lvl(src_idle), .start(src_start), .n(src_n),
    .width(src_w), .pin(src_pin), .busy(src_busy)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] wd,
                      output logic [31:0] rdat);
    int k;
    k = 0;
    WB_CYC <= 1'b1;
    WB_STB <= 1'b1;
    WB_WE <= we;
    WB_ADR <= a;
    WB_SEL <= bus_sel;
    WB_WDATA <= wd;
    do @(posedge SYS_CLK); while (WB_ACK !== 1'b1 && ++k < 20);
    if (k >= 20) bad_count++;
    rdat = WB_RDATA;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
    WB_WE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] unused;
    xfer(a, 1'b1, wd, unused);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
    xfer(a, 1'b0, 32'h0000_0000, rdat);
  endtask : rd
  task automatic pulse(input logic [7:0] n, input logic [7:0] w);
    int k;
    k = 0;
    src_n <= n;
    src_w <= w;
    src_start <= 1'b1;
    @(posedge SYS_CLK);
    src_start <= 1'b0;
    do @(posedge SYS_CLK); while (src_busy === 1'b1 && ++k < 2000);
    repeat (8) @(posedge SYS_CLK);
  endtask : pulse
  task automatic level(input logic v);
    src_idle <= v;
    repeat (8) @(posedge SYS_CLK);
  endtask : level
  task automatic t_reset();
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(A_CH + 8'(4 * i), d);
      chk(d, 32'h0000_0000);
    end
    rd(A_ACTL, d);
    chk(d, 32'h0000_0000);
    rd(8'hFC, d);
    chk(d, 32'h0000_0000);
  endtask : t_reset
  task automatic t_chan();
    logic [31:0] d, t;
    int k;
    k = 0;
    wr(A_DIR, 32'h0000_0008);
    wr(A_TSC1, 32'h0000_0080);
    wr(A_CH + 8'h08, 32'h0000_1234);
    rd(A_CH + 8'h08, d);
    chk(d, 32'h0000_0000);
    rd(A_TCNT, t);
    wr(A_CH + 8'h0C, {16'h0000, t[15:0] + 16'h0028});
    while (OC_MATCH[3] !== 1'b1 && k++ < 60) @(posedge SYS_CLK);
    chk({31'h0, OC_MATCH[3] === 1'b1}, 32'h0000_0001);
    rd(A_CH + 8'h0C, d);
    chk(d, {16'h0000, t[15:0] + 16'h0028});
    // Byte halves of a channel word: high byte first
    bus_sel = 4'h2;
    wr(A_CH + 8'h0C, 32'h0000_AB00);
    bus_sel = 4'h1;
    wr(A_CH + 8'h0C, 32'h0000_00CD);
    bus_sel = 4'h3;
    rd(A_CH + 8'h0C, d);
    chk(d, 32'h0000_ABCD);
    rd(A_TCNT, t);
    ch_lo[2] <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    ch_lo[2] <= 1'b0;
    rd(A_CH + 8'h08, d);
    chk({31'h0, (d[15:0] - t[15:0]) inside {[16'h0001:16'h0014]}}, 32'h0000_0001);
  endtask : t_chan
  task automatic t_event();
    logic [31:0] d;
    wr(A_TSC1, 32'h0000_0000);
    wr(A_ACTL, 32'h0000_0053);
    wr(A_ACNT, 32'h0000_FFFE);
    pulse(8'h03, 8'h04);
    rd(A_ACNT, d);
    chk(d, 32'h0000_0001);
    rd(A_AFLG, d);
    chk(d, 32'h0000_0003);
    chk({30'h0, ACCUM_OVF_IRQ, ACCUM_IN_IRQ}, 32'h0000_0003);
    wr(A_ACNT, 32'h0000_0000);
    for (int e = 0; e < 2; e++) begin
      wr(A_ACTL, (e == 1) ? 32'h0000_0050 : 32'h0000_0040);
      level(1'b1);
      rd(A_ACNT, d);
      chk(d, 32'(2 * e));
      level(1'b0);
      rd(A_ACNT, d);
      chk(d, 32'(1 + e));
    end
    // Read right behind a counted edge still lacks it
    src_idle <= 1'b1;
    rd(A_ACNT, d);
    chk(d, 32'h0000_0002);
    level(1'b1);
    rd(A_ACNT, d);
    chk(d, 32'h0000_0003);
    level(1'b0);
  endtask : t_event
  task automatic t_flags();
    logic [31:0] d;
    wr(A_ACTL, 32'h0000_0053);
    wr(A_AFLG, 32'h0000_0003);
    rd(A_AFLG, d);
    chk(d, 32'h0000_0003);
    wr(A_TSC1, 32'h0000_0080);
    wr(A_AFLG, 32'h0000_0001);
    rd(A_AFLG, d);
    chk(d, 32'h0000_0002);
    wr(A_TSC1, 32'h0000_0090);
    rd(A_ACNT, d);
    rd(A_AFLG, d);
    chk(d, 32'h0000_0000);
  endtask : t_flags
  task automatic t_gated();
    logic [31:0] d;
    wr(A_TSC1, 32'h0000_0080);
    wr(A_ACTL, 32'h0000_0060);
    wr(A_ACNT, 32'h0000_0000);
    pulse(8'h01, 8'h80);
    rd(A_ACNT, d);
    chk(d, 32'h0000_0002);
    rd(A_AFLG, d);
    chk(d, 32'h0000_0001);
    wr(A_TSC1, 32'h0000_0000);
    pulse(8'h01, 8'h80);
    rd(A_ACNT, d);
    chk(d, 32'h0000_0002);
    wr(A_TSC1, 32'h0000_0080);
    wr(A_AFLG, 32'h0000_0003);
    wr(A_ACTL, 32'h0000_0000);
    level(1'b1);
    pulse(8'h03, 8'h04);
    rd(A_ACNT, d);
    chk(d, 32'h0000_0002);
    rd(A_AFLG, d);
    chk(d, 32'h0000_0000);
    wr(A_ACTL, 32'h0000_0070);
    wr(A_ACNT, 32'h0000_0000);
    pulse(8'h01, 8'h80);
    rd(A_ACNT, d);
    chk(d, 32'h0000_0002);
    wr(A_ACTL, 32'h0000_0000);
    level(1'b0);
  endtask : t_gated
  task automatic t_clksel();
    logic [31:0] d, t;
    for (int s = 1; s < 4; s++) begin
      wr(A_ACTL, 32'h0000_0040 | 32'(s << 2));
      wr(A_ACNT, (s == 1) ? 32'h0 : (s == 2) ? 32'h0000_00FE : 32'h0000_FFFE);
      rd(A_TCNT, t);
      pulse((s == 1) ? 8'h03 : 8'h02, 8'h04);
      rd(A_TCNT, d);
      chk({16'h0000, d[15:0] - t[15:0]}, (s == 1) ? 32'h3 : 32'h1);
    end
    wr(A_ACTL, 32'h0000_000C);
    rd(A_TCNT, t);
    rd(A_TCNT, d);
    chk({31'h0, d !== t}, 32'h0000_0001);
  endtask : t_clksel
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    t_reset();
    t_chan();
    t_event();
    t_flags();
    t_gated();
    t_clksel();
    end_sim();
  end
  // Whole sequence needs under two thousand cycles
  initial begin
    repeat (40000) @(posedge SYS_CLK);
    bad_count++;
    end_sim();
  end
endmodule : tb_pulse_accumulator_channel_regs
